// File: bench/pdr_pin_model.sv
// Behavioural model of the port pins and the circuitry hung on them
`timescale 1ns/1ps
`default_nettype none

module pdr_pin_model (
    input  wire logic                clk,
    input  wire pdr_pkg::pdr_bytes_t pin_out,
    input  wire pdr_pkg::pdr_bytes_t pin_oe_n,
    input  wire pdr_pkg::pdr_bytes_t pin_pullup,
    input  wire pdr_pkg::pdr_bytes_t ext_val,
    input  wire pdr_pkg::pdr_bytes_t ext_en,
    output var pdr_pkg::pdr_bytes_t  pin_in
);
    import pdr_pkg::*;

    logic tog; // Floating pins wander so no stale level reads as valid

    initial tog = 1'b0;

    // Wander pattern flips every cycle
    always @(posedge clk) tog <= ~tog;

    // Driven pin wins, then the outside driver, then the pull-up
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            for (int b = 0; b < 8; b++) begin
                if (!pin_oe_n[i][b])
                    pin_in[i][b] = pin_out[i][b];
                else if (ext_en[i][b])
                    pin_in[i][b] = ext_val[i][b];
                else if (pin_pullup[i][b])
                    pin_in[i][b] = 1'b1;
                else
                    pin_in[i][b] = tog ^ b[0];
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_pdr_port_regs.sv
// Self-checking bench for the port direction and data register bank
`timescale 1ns/1ps
`default_nettype none

module tb_pdr_port_regs;
    import pdr_pkg::*;

    logic       clk = 1'b0;       // 50 ns clock
    logic       rst_n = 1'b0;     // Async reset, low
    logic       ce = 1'b1;        // Clock enable
    pdr_req_t   req = '0;         // Bus request
    logic [7:0] rd_data;          // Read answer
    logic [3:0] clk_mode = 4'h0;  // Port 12 clock-input modes
    pdr_bytes_t pin_in;           // Pin levels from the model
    pdr_bytes_t seg_drive = '0;   // Segment data
    pdr_bytes_t pin_out;          // Pin drive values
    pdr_bytes_t pin_oe_n;         // Pin drive enables
    pdr_bytes_t pin_pullup;       // Pull-up enables
    pdr_bytes_t ext_val = '0;     // Outside driver levels
    pdr_bytes_t ext_en = '1;      // Outside driver enables
    pdr_bytes_t sh_dir;           // Shadow of direction registers
    pdr_bytes_t sh_lat;           // Shadow of output latches
    logic [7:0] exp_q[$];         // Expected read answers, oldest first
    logic       rd_q = 1'b0;      // A read was taken last edge
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cycles = 0;

    pdr_port_regs dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
        .rd_data(rd_data), .pin_in(pin_in), .clk_mode(clk_mode),
        .seg_drive(seg_drive), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup));

    pdr_pin_model pins_u (.clk(clk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    // Free-running clock
    always #25 clk = ~clk;

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One-cycle write; shadow follows only when the write will be taken
    task automatic wr(input pdr_addr_t a, input logic [7:0] d,
                      input logic [7:0] m);
        for (int i = 0; i < NPORT; i++) begin
            if (ce && a == DIR_OFS[i])
                sh_dir[i] = (sh_dir[i] & ~m) | (d & m);
            if (ce && a == DATA_OFS[i])
                sh_lat[i] = ((sh_lat[i] & ~m) | (d & m)) & IMPL_MASK[i];
        end
        req <= '{addr: a, wdata: d, wmask: m, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask

    // One-cycle read; the answer is noted for the monitor
    task automatic rd(input pdr_addr_t a, input logic [7:0] e);
        exp_q.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wmask: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
    endtask

    // Drop strobes and let cycles pass
    task automatic idle(input int n);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Pin drive versus shadow, segment mode off
    task automatic pins(input int i);
        logic [7:0] m;
        m = IMPL_MASK[i] & ~sh_dir[i];
        check(pin_oe_n[i] & IMPL_MASK[i], sh_dir[i] & IMPL_MASK[i]);
        check(pin_out[i] & m, sh_lat[i] & m);
    endtask

    // Input bits give pin level, output bits give latch
    function automatic logic [7:0] exp_data(input int i);
        logic [7:0] v;
        v = ((sh_dir[i] & ext_val[i]) | (~sh_dir[i] & sh_lat[i]));
        v = v & IMPL_MASK[i];
        if (i == IDX_P12)
            v = v | (ext_val[i] & P12_IN_MASK & ~{3'h0, clk_mode, 1'b0});
        return v;
    endfunction

    // Read monitor: answer stands one cycle after the strobe
    always @(posedge clk) rd_q <= req.rd & ce;
    always @(negedge clk) begin
        if (rd_q && exp_q.size() > 0)
            check(rd_data, exp_q.pop_front());
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h8add));
        for (int i = 0; i < NPORT; i++)
            ext_val[i] = 8'($urandom);
        clk_mode = 4'($urandom);
        sh_dir = '1;
        sh_lat = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset state of pins and registers
        for (int i = 0; i < NPORT; i++) begin
            check(pin_oe_n[i], DIR_RST);
            check(pin_out[i], DATA_RST);
            check(pin_pullup[i], PU_RST);
            rd(DIR_OFS[i], DIR_RST);
            rd(DATA_OFS[i], exp_data(i));
        end
        rd(SEG_OFS, SEG_RST);
        rd(PORT14_PULLUP_SELECT_OFS, PU_RST);
        // Random latch and direction on every port, back to back
        for (int i = 0; i < NPORT; i++) begin
            wr(DATA_OFS[i], 8'($urandom), 8'hff);
            wr(DIR_OFS[i], 8'($urandom | ~IMPL_MASK[i]), 8'hff);
        end
        idle(3);
        for (int i = 0; i < NPORT; i++) begin
            pins(i);
            rd(DATA_OFS[i], exp_data(i));
            rd(DIR_OFS[i], sh_dir[i]);
        end
        // Single-bit writes on ports 14 and 15
        for (int i = IDX_P14; i <= IDX_P15; i++) begin
            for (int k = 0; k < 4; k++) begin
                wr(DATA_OFS[i], 8'hff, 8'h01 << k);
                wr(DIR_OFS[i], 8'h00, 8'h01 << k);
            end
        end
        idle(3);
        pins(IDX_P14);
        pins(IDX_P15);
        // Pull-ups only on floating inputs; outsiders let go
        ext_en[IDX_P14] <= 8'h00;
        ext_en[IDX_P15] <= 8'h00;
        wr(PORT14_PULLUP_SELECT_OFS, 8'hff, 8'hff);
        wr(PORT15_PULLUP_SELECT_OFS, 8'hff, 8'hff);
        wr(DIR_OFS[IDX_P14], 8'hfc, 8'hff);
        wr(DIR_OFS[IDX_P15], 8'hf3, 8'hff);
        idle(3);
        check(pin_pullup[IDX_P14] & PU_MASK, 8'h0c);
        check(pin_pullup[IDX_P15] & PU_MASK, 8'h03);
        rd(DATA_OFS[IDX_P14], 8'h0f);
        rd(PORT15_PULLUP_SELECT_OFS, PU_MASK);
        // Segment drive takes ports 14 and 15, pull-ups drop
        for (int i = 0; i < NPORT; i++)
            seg_drive[i] <= 8'($urandom);
        wr(SEG_OFS, 8'hff, 8'hff);
        idle(3);
        for (int i = IDX_P14; i <= IDX_P15; i++) begin
            check(pin_oe_n[i] & 8'h0f, 8'h00);
            check(pin_out[i] & 8'h0f, seg_drive[i] & 8'h0f);
            check(pin_pullup[i] & 8'h0f, 8'h00);
        end
        rd(SEG_OFS, SEG_MASK);
        // Unmapped place, then a write while frozen
        wr(16'hff05, 8'hff, 8'hff);
        rd(16'hff05, RD_IDLE);
        ce <= 1'b0;
        idle(1);
        wr(DATA_OFS[0], 8'hff, 8'hff);
        idle(1);
        ce <= 1'b1;
        rd(DATA_OFS[0], exp_data(0));
        idle(2);
        complete_run();
    end
endmodule
`default_nettype wire

// File: rtl/pdr_pin_slice.sv
// Pin driver stage for one port: output value, enable and pull-up
`timescale 1ns/1ps
`default_nettype none

module pdr_pin_slice #(
    parameter logic [7:0] MASK = 8'hff
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [7:0] latch,
    input  wire logic [7:0] dir,
    input  wire logic [7:0] pu_sel,
    input  wire logic       seg_en,
    input  wire logic [7:0] seg_drive,
    output logic [7:0]      pin_out,
    output logic [7:0]      pin_oe_n,
    output logic [7:0]      pin_pu
);
    import pdr_pkg::*;

    // Whole state of the slice
    typedef struct packed {
        logic [7:0] out;   // Level driven when enabled
        logic [7:0] oe_n;  // Low while driving
        logic [7:0] pu;    // Pull-up connected
    } pdr_slice_t;

    pdr_slice_t st;       // Registered pin state
    pdr_slice_t next_st;  // Next pin state

    // Pin decision, one cycle behind the registers
    always_comb begin
        next_st = st;
        if (seg_en) begin
            // Segment use owns the pin, never pulled up
            next_st.out  = seg_drive & MASK;
            next_st.oe_n = ~MASK;
            next_st.pu   = 8'h00;
        end else begin
            // Direction 0 drives the latch, 1 floats it
            next_st.out  = latch & ~dir & MASK;
            next_st.oe_n = dir | ~MASK;
            // Pull-up only on input bits that select it
            next_st.pu   = dir & pu_sel & MASK;
        end
    end

    // Pins float with no pull-up while in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{out: DATA_RST, oe_n: DIR_RST, pu: PU_RST};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pin_out  = st.out;
    assign pin_oe_n = st.oe_n;
    assign pin_pu   = st.pu;

endmodule

`default_nettype wire

// File: rtl/pdr_pkg.sv
// Shared constants and types for the port direction and data register bank
package pdr_pkg;

    // Number of ports held in the bank, in index order 1,2,3,4,10,11,12,14,15
    localparam int NPORT = 9;

    // Port indices used by port-specific logic
    localparam int IDX_P10 = 4;
    localparam int IDX_P11 = 5;
    localparam int IDX_P12 = 6;
    localparam int IDX_P14 = 7;
    localparam int IDX_P15 = 8;

    // One byte per port, index 0 is port 1
    typedef logic [NPORT-1:0][7:0] pdr_bytes_t;

    // Register address as seen on the plain bus
    typedef logic [15:0] pdr_addr_t;

    // One bus request: address, data, per-bit write lanes and strobes
    typedef struct packed {
        pdr_addr_t  addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
        logic       wr;
        logic       rd;
    } pdr_req_t;

    // Data register offsets, highest index first
    localparam logic [NPORT-1:0][15:0] DATA_OFS = {
        16'hff0f, 16'hff0e, 16'hff0c, 16'hff0b, 16'hff0a,
        16'hff04, 16'hff03, 16'hff02, 16'hff01};

    // Direction register offsets, highest index first
    localparam logic [NPORT-1:0][15:0] DIR_OFS = {
        16'hff2f, 16'hff2e, 16'hff2c, 16'hff2b, 16'hff2a,
        16'hff24, 16'hff23, 16'hff22, 16'hff21};

    // Bits that exist as real pins with a latch, per port
    localparam logic [NPORT-1:0][7:0] IMPL_MASK = {
        8'h0f, 8'h0f, 8'h01, 8'h0c, 8'h03,
        8'h01, 8'h1e, 8'h3f, 8'h0c};

    // Bit of the segment select register owned by each port
    localparam logic [NPORT-1:0][7:0] SEG_SEL = {
        8'h40, 8'h20, 8'h00, 8'h08, 8'h04,
        8'h00, 8'h00, 8'h00, 8'h00};

    // Port 12 input-only pins, bits 1 to 4
    localparam logic [7:0] P12_IN_MASK = 8'h1e;
    localparam int         P12_IN_LSB  = 1;

    // Pull-up select and segment select registers
    localparam pdr_addr_t  PORT14_PULLUP_SELECT_OFS = 16'hff3e;
    localparam pdr_addr_t  PORT15_PULLUP_SELECT_OFS = 16'hff3f;
    localparam pdr_addr_t  SEG_OFS  = 16'hffb6;
    localparam logic [7:0] PU_MASK  = 8'h0f;
    localparam logic [7:0] SEG_MASK = 8'h6c;

    // Reset values
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] PU_RST   = 8'h00;
    localparam logic [7:0] SEG_RST  = 8'h00;
    localparam logic [7:0] RD_IDLE  = 8'h00;

endpackage

// File: rtl/pdr_port_regs.sv
// Port direction, data, pull-up and segment registers with pin drivers
//
// Functional notes
// - Port 14 four bidirectional bits with latch
// - Port 14 input pull-up when select set
// - Port 15 four bidirectional bits with latch
// - Port 15 input pull-up when select set
// - Ports 14 and 15 may drive segments
// - Reset puts ports 14 and 15 input
// - Direction 0 output driven, 1 input
// - Direction registers reset to all ones
// - Single-bit and byte writes both accepted
// - Data write updates latch, driven on outputs
// - Input-mode read returns pin level
// - Output-mode read returns latch contents
// - Data latches reset to zero
// - Port 12 bits 1-4 read-only, clock-mode zero
// - No pull-up on output or segment pins
// - Segment select bit, reset clears it
`timescale 1ns/1ps
`default_nettype none

module pdr_port_regs (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire pdr_pkg::pdr_req_t   req,
    output logic [7:0]               rd_data,
    input  wire pdr_pkg::pdr_bytes_t pin_in,
    input  wire logic [3:0]          clk_mode,
    input  wire pdr_pkg::pdr_bytes_t seg_drive,
    output pdr_pkg::pdr_bytes_t      pin_out,
    output pdr_pkg::pdr_bytes_t      pin_oe_n,
    output pdr_pkg::pdr_bytes_t      pin_pullup
);
    import pdr_pkg::*;

    // Whole state of the register bank
    typedef struct packed {
        pdr_bytes_t latch;    // Output latches
        pdr_bytes_t dir;      // Direction, 1 = input
        logic [7:0] port14_pullup_select;     // Port 14 pull-up select
        logic [7:0] port15_pullup_select;     // Port 15 pull-up select
        logic [7:0] seg;      // Segment select bits
        logic [7:0] rd_data;  // Read answer register
    } pdr_state_t;

    pdr_state_t st;       // Registered state
    pdr_state_t next_st;  // Next state

    pdr_bytes_t port_rd;  // Read value of each data register
    pdr_bytes_t pu_arr;   // Pull-up select per port
    logic [NPORT-1:0] seg_en;  // Segment use per port
    logic [7:0] p12_live;      // Port 12 pins readable now

    // Merge a write into a register, honouring the bit lanes
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] wm);
        merge = (old & ~wm) | (wd & wm);
    endfunction

    // Clock-mode pins of port 12 always read low
    always_comb begin
        p12_live = P12_IN_MASK & ~({4'h0, clk_mode} << P12_IN_LSB);
    end

    // Per-port read value, pull-up and segment use
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            // Inputs show the pin, outputs show the latch
            port_rd[i] = ((st.dir[i] & pin_in[i])
                         | (~st.dir[i] & st.latch[i]))
                         & IMPL_MASK[i];
            pu_arr[i] = 8'h00;
            seg_en[i] = |(st.seg & SEG_SEL[i]);
        end
        // Port 12 upper pins are inputs with no latch
        port_rd[IDX_P12] = port_rd[IDX_P12]
                           | (pin_in[IDX_P12] & p12_live);
        // Only ports 14 and 15 carry pull-up selects here
        pu_arr[IDX_P14] = st.port14_pullup_select;
        pu_arr[IDX_P15] = st.port15_pullup_select;
    end

    // Register writes and read answer
    always_comb begin
        next_st = st;
        // Read data stand only in the cycle after the strobe
        next_st.rd_data = RD_IDLE;
        for (int i = 0; i < NPORT; i++) begin
            if (req.wr && req.addr == DATA_OFS[i]) begin
                // Latch only the bits that have a pin
                next_st.latch[i] = merge(st.latch[i], req.wdata,
                                         req.wmask) & IMPL_MASK[i];
            end
            if (req.wr && req.addr == DIR_OFS[i]) begin
                // Whole byte kept; unused bits are expected to be ones
                next_st.dir[i] = merge(st.dir[i], req.wdata,
                                       req.wmask);
            end
            if (req.rd && req.addr == DATA_OFS[i]) begin
                next_st.rd_data = port_rd[i];
            end
            if (req.rd && req.addr == DIR_OFS[i]) begin
                next_st.rd_data = st.dir[i];
            end
        end
        if (req.wr && req.addr == PORT14_PULLUP_SELECT_OFS) begin
            next_st.port14_pullup_select = merge(st.port14_pullup_select, req.wdata, req.wmask) & PU_MASK;
        end
        if (req.wr && req.addr == PORT15_PULLUP_SELECT_OFS) begin
            next_st.port15_pullup_select = merge(st.port15_pullup_select, req.wdata, req.wmask) & PU_MASK;
        end
        if (req.wr && req.addr == SEG_OFS) begin
            next_st.seg = merge(st.seg, req.wdata,
                                req.wmask) & SEG_MASK;
        end
        if (req.rd && req.addr == PORT14_PULLUP_SELECT_OFS) begin
            next_st.rd_data = st.port14_pullup_select;
        end
        if (req.rd && req.addr == PORT15_PULLUP_SELECT_OFS) begin
            next_st.rd_data = st.port15_pullup_select;
        end
        if (req.rd && req.addr == SEG_OFS) begin
            next_st.rd_data = st.seg;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{latch:   {NPORT{DATA_RST}},
                    dir:     {NPORT{DIR_RST}},
                    port14_pullup_select:    PU_RST,
                    port15_pullup_select:    PU_RST,
                    seg:     SEG_RST,
                    rd_data: RD_IDLE};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;

    // One driver stage per port; pins follow registers a cycle later
    for (genvar g = 0; g < NPORT; g++) begin : g_port
        pdr_pin_slice #(
            .MASK (IMPL_MASK[g])
        ) u_slice (
            .clk       (clk),
            .rst_n     (rst_n),
            .ce        (ce),
            .latch     (st.latch[g]),
            .dir       (st.dir[g]),
            .pu_sel    (pu_arr[g]),
            .seg_en    (seg_en[g]),
            .seg_drive (seg_drive[g]),
            .pin_out   (pin_out[g]),
            .pin_oe_n  (pin_oe_n[g]),
            .pin_pu    (pin_pullup[g])
        );
    end

    // Checks share one clock and the reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Full-byte write to a port 14 direction
    sequence s_dir14_wr;
        ce && req.wr && req.addr == DIR_OFS[IDX_P14] && req.wmask == 8'hff;
    endsequence

    // Full-byte write to the port 15 latch
    sequence s_lat15_wr;
        ce && req.wr && req.addr == DATA_OFS[IDX_P15]
        && req.wmask == 8'hff;
    endsequence

    // Direction write lands next cycle
    chk_dir_write_lands: assert property (
        s_dir14_wr |=> st.dir[IDX_P14] == $past(req.wdata))
        else $error("direction write not stored");

    // Latch write lands, masked to real pins
    chk_latch_write_lands: assert property (
        s_lat15_wr |=> st.latch[IDX_P15] == ($past(req.wdata) & 8'h0f))
        else $error("latch write not stored");

    // Input bits read the pin level
    chk_read_input_pin: assert property (
        ce && req.rd && req.addr == DATA_OFS[IDX_P14]
        && st.dir[IDX_P14] == 8'hff && !req.wr
        |=> rd_data == ($past(pin_in[IDX_P14]) & 8'h0f))
        else $error("input read not pin level");

    // Output bits read the latch, not the pin
    chk_read_output_latch: assert property (
        ce && req.rd && req.addr == DATA_OFS[IDX_P14]
        && st.dir[IDX_P14][3:0] == 4'h0
        |=> rd_data[3:0] == $past(st.latch[IDX_P14][3:0]))
        else $error("output read not latch");

    // Output bit drives its latch one cycle later
    chk_pin_drive_out: assert property (
        ce && !st.dir[IDX_P14][0] && !seg_en[IDX_P14]
        |=> !pin_oe_n[IDX_P14][0]
            && pin_out[IDX_P14][0] == $past(st.latch[IDX_P14][0]))
        else $error("output pin not driven from latch");

    // Output bit never gets a pull-up
    chk_no_pullup_out: assert property (
        ce && !st.dir[IDX_P15][2] ##1 ce |-> !pin_pullup[IDX_P15][2])
        else $error("pull-up on output pin");

    // Selected input bit gets a pull-up
    chk_pullup_input: assert property (
        ce && st.dir[IDX_P14][1] && st.port14_pullup_select[1] && !seg_en[IDX_P14]
        |=> pin_pullup[IDX_P14][1] && pin_oe_n[IDX_P14][1])
        else $error("selected pull-up missing");

    // Segment use drives segment data
    chk_seg_drive: assert property (
        ce && seg_en[IDX_P15]
        |=> !pin_oe_n[IDX_P15][3] && !pin_pullup[IDX_P15][3]
            && pin_out[IDX_P15][3] == $past(seg_drive[IDX_P15][3]))
        else $error("segment pin not driven");

    // Clock-mode pin of port 12 reads low
    chk_p12_clock_mode: assert property (
        ce && req.rd && req.addr == DATA_OFS[IDX_P12] && clk_mode[0]
        |=> rd_data[1] == 1'b0)
        else $error("clock-mode pin not read low");

    // Just after reset pins float with latches clear
    chk_reset_state: assert property (
        $rose(rst_n) |-> st.dir[IDX_P14] == 8'hff
        && st.latch[IDX_P15] == 8'h00 && pin_oe_n[IDX_P14] == 8'hff)
        else $error("reset state wrong");

    // Full-byte write to the port 15 pull-up select
    sequence s_port15_pullup_select_wr;
        ce && req.wr && req.addr == PORT15_PULLUP_SELECT_OFS && req.wmask == 8'hff;
    endsequence

    // Full-byte write to the segment select register
    sequence s_seg_wr;
        ce && req.wr && req.addr == SEG_OFS && req.wmask == 8'hff;
    endsequence

    // Cycle with no read taken
    sequence s_no_read;
        ce && !req.rd;
    endsequence

    // Pull-up select write lands, only real pins kept
    chk_pullup_sel_write: assert property (
        s_port15_pullup_select_wr |=> st.port15_pullup_select == ($past(req.wdata) & PU_MASK))
        else $error("pull-up select write not stored");

    // Segment select write lands on its own bits
    chk_seg_sel_write: assert property (
        s_seg_wr |=> st.seg == ($past(req.wdata) & SEG_MASK))
        else $error("segment select write not stored");

    // Read answer lasts one cycle, idle otherwise
    chk_idle_read_zero: assert property (
        s_no_read |=> rd_data == RD_IDLE)
        else $error("read answer not idle");

    // Frozen clock enable keeps every register
    chk_freeze_hold: assert property (
        !ce |=> $stable(st))
        else $error("state moved while frozen");

    // Input bit floats its output buffer
    chk_input_floats: assert property (
        ce && st.dir[IDX_P15][0] && !seg_en[IDX_P15]
        |=> pin_oe_n[IDX_P15][0] && pin_out[IDX_P15][0] == 1'b0)
        else $error("input pin still driven");

    // Port 15 and the segment select start from reset values
    chk_reset_regs: assert property (
        $rose(rst_n) |-> st.dir[IDX_P15] == DIR_RST
        && st.seg == SEG_RST && st.port14_pullup_select == PU_RST
        && st.port15_pullup_select == PU_RST && rd_data == RD_IDLE)
        else $error("reset register values wrong");

    // Port 12 clock-shared pins never hold a latch bit
    chk_p12_no_latch: assert property (
        ce ##1 ce |-> (st.latch[IDX_P12] & P12_IN_MASK) == 8'h00)
        else $error("port 12 input pin latched");

endmodule

`default_nettype wire
